// file: testbench/plmc_board.sv
// board-side model: drives the dedicated pins and resolves the shared macrocell pins
module plmc_board (
    input  wire       clk_i,
    input  wire [7:0] dev_pin_i,
    input  wire [7:0] dev_oe_i,
    output reg  [9:0] din_o,
    output reg        clk_pin_o,
    output reg        oe_pin_b_o,
    output reg        pd_pin_o,
    output wire [7:0] io_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // board level on undriven shared pins; differs from the device's idle zero
    localparam [7:0] BOARD_IO = 8'hA5;

    initial begin
        din_o      = 10'h000;
        clk_pin_o  = 1'b0;
        oe_pin_b_o = 1'b1;
        pd_pin_o   = 1'b0;
    end

    // a shared pin shows the device's level wherever the device drives it
    assign io_pin_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & BOARD_IO);

    // levels change just after a rising edge; the standby pin position never carries data
    task automatic drive(input [9:0] din, input clkp, input oeb, input pd);
        @(posedge clk_i);
        din_o      <= din & 10'h3F7;
        clk_pin_o  <= clkp;
        oe_pin_b_o <= oeb;
        pd_pin_o   <= pd;
    endtask
endmodule

// file: testbench/plmc_checker_assertions.sv
// concurrent checks on the ports of the macrocell block
module plmc_checker #(
    parameter PD_VARIANT = 1
) (
    input wire        clk_i,
    input wire        rst_b_i,
    input wire [4:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    input wire [9:0]  din_pin_i,
    input wire        clk_pin_i,
    input wire        oe_pin_b_i,
    input wire        pd_pin_i,
    input wire [7:0]  io_pin_i,
    input wire [7:0]  io_pin_o,
    input wire [7:0]  io_oe_o,
    input wire        standby_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_req_answered: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    a_wait_idle: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
        |=> avs_waitrequest_o) else $error("answer without a request");
    a_upper_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i[4]
        |=> avs_readdata_o == 32'h0) else $error("write-only or unmapped read not zero");
    a_reset_clean: assert property ($rose(rst_b_i) |-> io_oe_o == 8'h00
        && io_pin_o == 8'h00 && !standby_o && avs_waitrequest_o)
        else $error("outputs not cleared by reset");
    a_standby_enter: assert property ((PD_VARIANT == 1 && pd_pin_i) [*4]
        |-> standby_o) else $error("standby not entered from power-down pin");
    a_standby_leave: assert property ((PD_VARIANT == 1 && !pd_pin_i) [*4]
        |-> !standby_o) else $error("standby held without power-down pin");
    a_standby_hold: assert property (standby_o && $past(standby_o)
        |-> $stable(io_pin_o) && $stable(io_oe_o)) else $error("outputs moved in standby");

    c_standby: cover property ($rose(standby_o));
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
    c_enable_term: cover property (io_oe_o == 8'h04);
endmodule

bind plmc_top plmc_checker #(.PD_VARIANT(PD_VARIANT)) plmc_checker_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .din_pin_i(din_pin_i), .clk_pin_i(clk_pin_i), .oe_pin_b_i(oe_pin_b_i),
    .pd_pin_i(pd_pin_i), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_oe_o(io_oe_o),
    .standby_o(standby_o));

// file: testbench/testbench.sv
// self-checking bench for the macrocell block
`include "plmc_map.vh"
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        num_errors++; \
        $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    reg         clk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg  [4:0]  avs_address_i = 5'h00;
    reg         avs_read_i = 1'b0;
    reg         avs_write_i = 1'b0;
    reg  [31:0] avs_writedata_i = 32'h0;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o;
    wire [9:0]  din_pin;
    wire        clk_pin;
    wire        oe_pin_b;
    wire        pd_pin;
    wire [7:0]  io_pin_in;
    wire [7:0]  io_pin_o;
    wire [7:0]  io_oe_o;
    wire        standby_o;
    int         num_errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    reg  [31:0] rd;

    plmc_top plmc_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .din_pin_i(din_pin), .clk_pin_i(clk_pin), .oe_pin_b_i(oe_pin_b), .pd_pin_i(pd_pin),
        .io_pin_i(io_pin_in), .io_pin_o(io_pin_o), .io_oe_o(io_oe_o), .standby_o(standby_o));
    plmc_board board_i (.clk_i(clk_i), .dev_pin_i(io_pin_o), .dev_oe_i(io_oe_o),
        .din_o(din_pin), .clk_pin_o(clk_pin), .oe_pin_b_o(oe_pin_b), .pd_pin_o(pd_pin),
        .io_pin_o(io_pin_in));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // bus master and helpers
    // ------------------------------------------------------------------
    task automatic wr(input [4:0] a, input [31:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    task automatic rdr(input [4:0] a);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_read_i    <= 1'b1;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask
    // outputs trail a pin change by up to two array sweeps
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic prog(input [5:0] idx, input [19:0] t);
        wr(`PLMC_OFS_PT_INDEX, {26'h0, idx});
        wr(`PLMC_OFS_PT_TRUE, {12'h0, t});
        wr(`PLMC_OFS_PT_COMP, 32'h0);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rdr(`PLMC_OFS_CTRL);
        `CHK(rd, `PLMC_CTRL_RESET)
        rdr(`PLMC_OFS_STATUS);
        `CHK(rd[1:0], `PLMC_MODE_SIMP)
        `CHK(rd[31:24], 8'h00)
        `CHK(io_oe_o, 8'h00)
        wr(5'h18, 32'hFFFF_FFFF);
        rdr(5'h18);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_modes;
        reg [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = (i[0] == 1'b0) ? `PLMC_MODE_REG : (i[1] ? `PLMC_MODE_CPLX : `PLMC_MODE_SIMP);
            wr(`PLMC_OFS_CTRL, {29'h0, i[1:0], 1'b0});
            rdr(`PLMC_OFS_STATUS);
            `CHK(rd[1:0], m)
        end
    endtask
    task automatic t_simple;
        board_i.drive(10'h000, 1'b0, 1'b1, 1'b0);
        prog(6'd1, 20'h00001);
        wr(`PLMC_OFS_CTRL, 32'h00FE_0203);
        settle(100);
        `CHK(io_oe_o, 8'h19)
        `CHK(io_pin_o, 8'h02)
        board_i.drive(10'h001, 1'b0, 1'b1, 1'b0);
        settle(100);
        `CHK(io_pin_o, 8'h03)
        wr(`PLMC_OFS_CTRL, 32'h0000_0001);
        rdr(`PLMC_OFS_CTRL);
        `CHK(rd, 32'h00FE_0203)
    endtask
    task automatic t_reg;
        wr(`PLMC_OFS_CTRL, 32'h0);
        wr(`PLMC_OFS_CTRL, 32'h0000_0001);
        board_i.drive(10'h001, 1'b0, 1'b0, 1'b0);
        settle(100);
        `CHK(io_oe_o, 8'hFF)
        `CHK(io_pin_o, 8'h00)
        wr(`PLMC_OFS_PRELOAD, 32'h0000_00A5);
        rdr(`PLMC_OFS_STATUS);
        `CHK(rd[31:24], 8'hA5)
        settle(100);
        `CHK(io_pin_o, 8'hA5)
        board_i.drive(10'h001, 1'b1, 1'b0, 1'b0);
        board_i.drive(10'h001, 1'b0, 1'b0, 1'b0);
        settle(100);
        rdr(`PLMC_OFS_STATUS);
        `CHK(rd[31:24], 8'h01)
        `CHK(io_pin_o, 8'h01)
        board_i.drive(10'h001, 1'b0, 1'b1, 1'b0);
        settle(100);
        `CHK(io_oe_o, 8'h00)
    endtask
    task automatic t_cplx;
        wr(`PLMC_OFS_CTRL, 32'h0);
        wr(`PLMC_OFS_CTRL, 32'h0000_0007);
        // in complex mode the clock pin reaches the array over cell 0's feedback column
        prog(6'h10, 20'h01000);
        board_i.drive(10'h001, 1'b1, 1'b1, 1'b0);
        settle(100);
        `CHK(io_oe_o, 8'h04)
        `CHK(io_pin_o[0], 1'b1)
        board_i.drive(10'h001, 1'b0, 1'b1, 1'b0);
        settle(100);
        `CHK(io_oe_o, 8'h00)
    endtask
    task automatic t_standby;
        board_i.drive(10'h001, 1'b1, 1'b1, 1'b0);
        settle(100);
        board_i.drive(10'h001, 1'b1, 1'b1, 1'b1);
        settle(5);
        `CHK(standby_o, 1'b1)
        board_i.drive(10'h000, 1'b0, 1'b1, 1'b1);
        settle(100);
        `CHK(io_pin_o[0], 1'b1)
        `CHK(io_oe_o, 8'h04)
        board_i.drive(10'h000, 1'b0, 1'b1, 1'b0);
        settle(100);
        `CHK(standby_o, 1'b0)
        `CHK(io_oe_o, 8'h00)
    endtask

    // a hang costs one mismatch and still reaches the report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_modes();
        t_simple();
        t_reg();
        t_cplx();
        t_standby();
        close_out();
    end
endmodule

// file: verilog/plmc_map.vh
// register offsets, field positions, reset values and timing for the macrocell block
`ifndef PLMC_MAP_VH
`define PLMC_MAP_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define PLMC_OFS_CTRL      5'h00
`define PLMC_OFS_STATUS    5'h04
`define PLMC_OFS_PT_INDEX  5'h08
`define PLMC_OFS_PT_TRUE   5'h0C
`define PLMC_OFS_PT_COMP   5'h10
`define PLMC_OFS_PRELOAD   5'h14

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define PLMC_CTRL_RUN      0
`define PLMC_CTRL_SYNC     1
`define PLMC_CTRL_ARCH     2
`define PLMC_CTRL_POL_LO   8
`define PLMC_CTRL_IO_LO    16
`define PLMC_CTRL_RESET    32'h0000_0002

// ------------------------------------------------------------------
// status register fields
// ------------------------------------------------------------------
`define PLMC_STAT_MODE_LO  0
`define PLMC_STAT_STANDBY  2
`define PLMC_STAT_OUT_LO   8
`define PLMC_STAT_OE_LO    16
`define PLMC_STAT_Q_LO     24

// ------------------------------------------------------------------
// global modes
// ------------------------------------------------------------------
`define PLMC_MODE_REG      2'h0
`define PLMC_MODE_CPLX     2'h1
`define PLMC_MODE_SIMP     2'h2

// ------------------------------------------------------------------
// array layout and timing
// ------------------------------------------------------------------
`define PLMC_CELLS         8
`define PLMC_TERMS         8
`define PLMC_DIN_W         10
`define PLMC_COLS          20
`define PLMC_COL_CLK       10
`define PLMC_COL_OE        11
`define PLMC_COL_FB_LO     12
`define PLMC_PD_INDEX      3
`define PLMC_CLK_NS        40
`define PLMC_TAS_NS        140

`endif

// file: verilog/plmc_mem.v
// product-term mask store: one write port for software, one registered read port
module plmc_mem #(
    parameter DW = 40,
    parameter AW = 6
) (
    input  wire          clk_i,
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    input  wire [AW-1:0] rd_addr_i,
    output reg  [DW-1:0] rd_data_o
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer i;

    // unprogrammed masks read as zero, which the array treats as a disabled term
    initial begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            mem[i] = {DW{1'b0}};
        end
    end

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// file: verilog/plmc_sync.v
// two-flop synchroniser for a bundle of asynchronous pin levels
module plmc_sync #(
    parameter W = 21
) (
    input  wire         clk_i,
    input  wire         rst_b_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// file: verilog/plmc_top.v
// eight-macrocell programmable array with three global modes and an avalon-mm register slave
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`include "plmc_map.vh"

// What this block does
// - three global modes apply to all cells
// - sync and global arch bits choose mode
// - per-cell polarity bit inverts output always
// - per-cell bit selects output or input/output
// - two global plus sixteen cell bits
// - registered: clock and enable pins never data
// - complex: pins use outer cells' feedback paths
// - simple: feedback via neighbour, inner cells none
// - power-down pin never a logic input
// - registered: shared clock and enable pins
// - registered: each cell register or input/output
// - registered: eight terms, input/output seven
// - complex: six input/outputs, outer cells none
// - complex: seven terms plus enable term
// - complex/simple: clock, enable pins feed array
// - simple: dedicated input or always-on output
// - simple: eight terms, programmable polarity
// - simple: centre cells never inputs
// - power-down variant: seventeen array inputs
// - standby by idle inputs or power-down pin
// - standby latches inputs, holds outputs while running
// - registers clear at reset, preload for test
// - registers capture on shared clock rising edge
module plmc_top #(
    parameter PD_VARIANT = 1
) (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire [4:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire [9:0]  din_pin_i,
    input  wire        clk_pin_i,
    input  wire        oe_pin_b_i,
    input  wire        pd_pin_i,
    input  wire [7:0]  io_pin_i,
    output reg  [7:0]  io_pin_o,
    output reg  [7:0]  io_oe_o,
    output reg         standby_o
);
    localparam NC = `PLMC_CELLS;
    localparam NV = `PLMC_COLS;
    localparam SW = `PLMC_DIN_W + 11;
    // longest idle time before standby, rounded down, never below one cycle
    localparam TAS_RAW = `PLMC_TAS_NS / `PLMC_CLK_NS;
    localparam TAS_CYC = (TAS_RAW < 1) ? 1 : TAS_RAW;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function [1:0] plmc_mode;
        input sync_bit;
        input arch_bit;
        begin
            if (!sync_bit) begin
                plmc_mode = `PLMC_MODE_REG;
            end else if (arch_bit) begin
                plmc_mode = `PLMC_MODE_CPLX;
            end else begin
                plmc_mode = `PLMC_MODE_SIMP;
            end
        end
    endfunction

    // a term with no literal is disabled and reads false
    function plmc_term;
        input [NV-1:0] v;
        input [NV-1:0] t;
        input [NV-1:0] c;
        begin
            plmc_term = ((t | c) != {NV{1'b0}}) && ((v & t) == t) && ((~v & c) == c);
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    wire [SW-1:0] pins_s;

    plmc_sync #(
        .W (SW)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     ({io_pin_i, pd_pin_i, oe_pin_b_i, clk_pin_i, din_pin_i}),
        .q_o     (pins_s)
    );

    wire [9:0] din_s   = pins_s[9:0];
    wire       clkp_s  = pins_s[10];
    wire       oeb_s   = pins_s[11];
    wire       pd_s    = pins_s[12];
    wire [7:0] iop_s   = pins_s[20:13];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg        run;
    reg        sync_mode_select_bit;
    reg        global_arch_bit;
    reg [7:0]  pol_bits;
    reg [7:0]  cell_io_select_bit;
    reg [5:0]  pt_index;
    reg [19:0] pt_true;
    reg [7:0]  cell_q;
    reg [7:0]  sum_q;
    reg [7:0]  oe_term_q;
    reg [7:0]  sum_acc;
    reg [7:0]  oe_acc;
    reg [5:0]  rd_idx;
    reg [5:0]  ev_idx;
    reg        ev_vld;
    reg [19:0] snap;
    reg        clkp_prev;
    reg [SW-1:0] last_pins;
    reg [2:0]  idle_cnt;

    wire [1:0]  mode     = plmc_mode(sync_mode_select_bit, global_arch_bit);
    wire        m_reg    = (mode == `PLMC_MODE_REG);
    wire        m_cplx   = (mode == `PLMC_MODE_CPLX);
    wire        m_simp   = (mode == `PLMC_MODE_SIMP);
    wire [39:0] rd_word;

    // ------------------------------------------------------------------
    // avalon slave: one wait cycle, then a single answer cycle
    // ------------------------------------------------------------------
    wire acc_done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    wire wr_go    = avs_write_i & ~avs_waitrequest_o;
    wire [4:0] wa = {avs_address_i[4:2], 2'b00};
    wire pt_wr    = wr_go && (wa == `PLMC_OFS_PT_COMP);
    wire pre_wr   = wr_go && (wa == `PLMC_OFS_PRELOAD);

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o) | acc_done;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (wa)
                `PLMC_OFS_CTRL: begin
                    avs_readdata_o <= {8'h00, cell_io_select_bit, pol_bits, 5'h00,
                                       global_arch_bit, sync_mode_select_bit, run};
                end
                `PLMC_OFS_STATUS: begin
                    avs_readdata_o <= {cell_q, io_oe_o, io_pin_o, 5'h00, standby_o, mode};
                end
                `PLMC_OFS_PT_INDEX: begin
                    avs_readdata_o <= {26'h000_0000, pt_index};
                end
                `PLMC_OFS_PT_TRUE: begin
                    avs_readdata_o <= {12'h000, pt_true};
                end
                default: begin
                    avs_readdata_o <= 32'h0000_0000;
                end
            endcase
        end
    end

    // architecture bits only change while stopped, so a running array never
    // sees its routing move under it
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            run                  <= 1'b0;
            sync_mode_select_bit <= |(`PLMC_CTRL_RESET & (32'h1 << `PLMC_CTRL_SYNC));
            global_arch_bit      <= 1'b0;
            pol_bits             <= 8'h00;
            cell_io_select_bit   <= 8'h00;
            pt_index             <= 6'h00;
            pt_true              <= 20'h0_0000;
        end else if (wr_go) begin
            case (wa)
                `PLMC_OFS_CTRL: begin
                    run <= avs_writedata_i[`PLMC_CTRL_RUN];
                    if (!run) begin
                        sync_mode_select_bit <= avs_writedata_i[`PLMC_CTRL_SYNC];
                        global_arch_bit      <= avs_writedata_i[`PLMC_CTRL_ARCH];
                        pol_bits             <= avs_writedata_i[`PLMC_CTRL_POL_LO +: 8];
                        cell_io_select_bit   <= avs_writedata_i[`PLMC_CTRL_IO_LO +: 8];
                    end
                end
                `PLMC_OFS_PT_INDEX: begin
                    pt_index <= avs_writedata_i[5:0];
                end
                `PLMC_OFS_PT_TRUE: begin
                    pt_true <= avs_writedata_i[19:0];
                end
                default: begin
                    pt_index <= pt_index;
                end
            endcase
        end
    end

    plmc_mem #(
        .DW (40),
        .AW (6)
    ) u_mem (
        .clk_i     (clk_i),
        .wr_en_i   (pt_wr),
        .wr_addr_i (pt_index),
        .wr_data_i ({avs_writedata_i[19:0], pt_true}),
        .rd_addr_i (rd_idx),
        .rd_data_o (rd_word)
    );

    // ------------------------------------------------------------------
    // routing of array columns per mode
    // ------------------------------------------------------------------
    reg [7:0]    io_eff;
    reg [7:0]    fb_col;
    reg [NV-1:0] col_en;
    integer k, j, n;

    always @* begin
        io_eff = cell_io_select_bit;
        fb_col = 8'h00;
        col_en = {NV{1'b1}};
        if (m_reg) begin
            col_en[`PLMC_COL_CLK] = 1'b0;
            col_en[`PLMC_COL_OE]  = 1'b0;
            for (k = 0; k < NC; k = k + 1) begin
                fb_col[k] = io_eff[k] ? iop_s[k] : cell_q[k];
            end
        end else if (m_cplx) begin
            io_eff[0] = 1'b0;
            io_eff[7] = 1'b0;
            col_en[`PLMC_COL_CLK] = 1'b0;
            col_en[`PLMC_COL_OE]  = 1'b0;
            fb_col    = iop_s;
            fb_col[0] = clkp_s;
            fb_col[7] = ~oeb_s;
        end else begin
            io_eff[3] = 1'b0;
            io_eff[4] = 1'b0;
            fb_col = {1'b0, iop_s[7:5], iop_s[2:0], 1'b0};
            col_en[`PLMC_COL_FB_LO]      = 1'b0;
            col_en[`PLMC_COL_FB_LO + 7]  = 1'b0;
        end
        if (PD_VARIANT != 0) begin
            col_en[`PLMC_PD_INDEX] = 1'b0;
        end
    end

    wire [NV-1:0] arr_in = {fb_col, ~oeb_s, clkp_s, din_s};

    // ------------------------------------------------------------------
    // standby detection
    // ------------------------------------------------------------------
    wire pins_moved = (pins_s != last_pins);
    wire standby_nx = (PD_VARIANT != 0) ? pd_s : (!pins_moved && idle_cnt == TAS_CYC[2:0]);

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            last_pins <= {SW{1'b0}};
            idle_cnt  <= 3'h0;
            standby_o <= 1'b0;
        end else begin
            last_pins <= pins_s;
            if (pins_moved) begin
                idle_cnt <= 3'h0;
            end else if (idle_cnt != TAS_CYC[2:0]) begin
                idle_cnt <= idle_cnt + 3'h1;
            end
            standby_o <= standby_nx;
        end
    end

    // ------------------------------------------------------------------
    // product-term sweep: one term per cycle, cell-major order
    // ------------------------------------------------------------------
    wire [2:0] ev_cell = ev_idx[5:3];
    wire [2:0] ev_tn   = ev_idx[2:0];
    wire       ev_hit  = plmc_term(snap, rd_word[19:0] & col_en, rd_word[39:20] & col_en);
    // term zero becomes the enable term for every cell in complex mode and for input/output cells in registered mode
    wire       tn0_oe  = m_cplx || (m_reg && io_eff[ev_cell]);
    wire       to_oe   = (ev_tn == 3'h0) && tn0_oe;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_idx    <= 6'h00;
            ev_idx    <= 6'h00;
            ev_vld    <= 1'b0;
            snap      <= {NV{1'b0}};
            sum_acc   <= 8'h00;
            oe_acc    <= 8'h00;
            sum_q     <= 8'h00;
            oe_term_q <= 8'h00;
        end else begin
            rd_idx <= rd_idx + 6'h01;
            ev_idx <= rd_idx;
            ev_vld <= 1'b1;
            if (rd_idx == 6'h00 && !standby_o) begin
                snap <= arr_in;
            end
            if (ev_vld) begin
                if (ev_tn == 3'h0) begin
                    sum_acc[ev_cell] <= ev_hit & ~to_oe;
                    oe_acc[ev_cell]  <= ev_hit & to_oe;
                end else begin
                    sum_acc[ev_cell] <= sum_acc[ev_cell] | ev_hit;
                end
                if (ev_tn == 3'h7 && !standby_o) begin
                    sum_q[ev_cell]     <= sum_acc[ev_cell] | ev_hit;
                    oe_term_q[ev_cell] <= oe_acc[ev_cell];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // macrocell registers on the shared clock pin
    // ------------------------------------------------------------------
    wire clkp_rise = clkp_s & ~clkp_prev;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            clkp_prev <= 1'b0;
            cell_q    <= 8'h00;
        end else begin
            clkp_prev <= clkp_s;
            if (pre_wr) begin
                cell_q <= avs_writedata_i[7:0];
            end else if (m_reg && run && clkp_rise && !standby_o) begin
                for (j = 0; j < NC; j = j + 1) begin
                    if (!io_eff[j]) begin
                        cell_q[j] <= sum_q[j];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------------
    reg [7:0] next_io_pin;
    reg [7:0] next_io_oe;

    always @* begin
        next_io_pin = 8'h00;
        next_io_oe  = 8'h00;
        for (n = 0; n < NC; n = n + 1) begin
            if (m_reg && !io_eff[n]) begin
                next_io_pin[n] = cell_q[n] ^ pol_bits[n];
                next_io_oe[n]  = ~oeb_s;
            end else if (m_reg) begin
                next_io_pin[n] = sum_q[n] ^ pol_bits[n];
                next_io_oe[n]  = oe_term_q[n];
            end else if (m_cplx) begin
                next_io_pin[n] = sum_q[n] ^ pol_bits[n];
                next_io_oe[n]  = oe_term_q[n];
            end else begin
                next_io_pin[n] = sum_q[n] ^ pol_bits[n];
                next_io_oe[n]  = ~io_eff[n];
            end
        end
        // a stopped array leaves every pin undriven
        if (!run) begin
            next_io_oe = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            io_pin_o <= 8'h00;
            io_oe_o  <= 8'h00;
        end else if (!standby_o || !run) begin
            io_pin_o <= next_io_pin;
            io_oe_o  <= next_io_oe;
        end
    end
endmodule
